// File: inc/pafm_pkg.sv
/*
 Constants for the port alternate-function mux: port width, reset values,
 analog pin configuration codes and bit-operation encodings.
 Assumes a single system clock and a synchronous active-high reset.
*/
package pafm_pkg;
   localparam int PAFM_W = 8;
   localparam logic [7:0] PAFM_LATCH_RST = 8'h00;
   localparam logic [7:0] PAFM_DIR_RST = 8'hff;
   localparam logic [4:0] PAFM_ANALOG_DIGITAL_PIN_CONFIG_RST = 5'h10;
   localparam logic [4:0] PAFM_ANALOG_DIGITAL_PIN_CONFIG_ALL_D0 = 5'h08;
   localparam logic [4:0] PAFM_ANALOG_DIGITAL_PIN_CONFIG_ALL_D1 = 5'h10;
   localparam logic [2:0] PAFM_ADS_W = 3'h7;
   localparam logic [1:0] PAFM_BOP_SET = 2'h1;
   localparam logic [1:0] PAFM_BOP_CLR = 2'h2;
   localparam logic [1:0] PAFM_BOP_NOT = 2'h3;
   localparam int PAFM_DAC_N = 2;
   localparam int PAFM_DBG_IO = 0;
   localparam int PAFM_DBG_OUT = 1;
   typedef enum logic [1:0] {PAFM_IDLE, PAFM_WRITE} pafm_phase_e;
endpackage

// File: rtl/pafm_port_mux.sv
/*
 Port pin logic for one 8-bit general-purpose port with alternate functions,
 the analog/digital selection of eight analog-capable pins, two debug pins
 and two D/A output pins. Software accesses arrive as plain strobes.
 Assumes pin inputs are synchronous to i_core_clk; the pad resolves the
 wire from output and output enable.
*/
// Operation
// RULE_01: Software sets direction and latch for the function before relying on it.
// RULE_02: Input-only alternate functions need direction 1; latch ignored.
// RULE_03: Timer outputs need direction 0 and latch 0. The code ANDs alternate outputs with the latch, so latch 0 holds the pin low.
// RULE_04: Serial data and UART transmit outputs need direction 0, latch 1.
// RULE_05: Serial clock input: direction 1; as output: direction 0, latch 1.
// RULE_06: Simple I2C clock and data pins: direction 0, latch 1.
// RULE_07: Dedicated I2C pins on port 6: direction 0, latch 0. The code ANDs alternate outputs with the latch, so latch 0 holds the pin low.
// RULE_08: RTC and clock/buzzer outputs: direction 0, latch 0. The code ANDs alternate outputs with the latch, so latch 0 holds the pin low.
// RULE_09: Debug tool pins work whatever their direction and latch hold.
// RULE_10: DAC enable 1 switches its pin to analog output automatically.
// RULE_11: Software keeps the DAC pin direction at input while in use.
// RULE_12: Digital analog-capable pin is input or output by its direction bit.
// RULE_13: Analog pin in input is converted only when selector picks it.
// RULE_14: Software never pairs analog selection with output direction.
// RULE_15: Input-mode bits: writes go to latch, reads return pin level.
// RULE_16: Bit instruction is 8-bit read, one-bit change, 8-bit write.
// RULE_17: Untargeted input bits may get their pin levels written to latch.
// RULE_18: Software should rewrite latch when switching a bit to output.
// RULE_19: Latches clear on reset and hold until the next write.
// RULE_20: Reading an output-mode bit returns the latch unchanged.
// RULE_21: Active alternate output is ANDed with the latch on the pin.
// RULE_22: Input alternate functions sample the pin whenever direction is 1.
`timescale 1ns/1ps
`default_nettype none
module pafm_port_mux
   import pafm_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_reset,
   input wire logic i_wr,
   input wire logic [7:0] i_wdata,
   input wire logic i_bit_op,
   input wire logic [1:0] i_bit_kind,
   input wire logic [2:0] i_bit_sel,
   input wire logic i_dir_wr,
   input wire logic [7:0] i_dir_wdata,
   input wire logic [7:0] i_alt_out_en,
   input wire logic [7:0] i_alt_out,
   input wire logic [7:0] i_pin_in,
   input wire logic [4:0] i_analog_digital_pin_config,
   input wire logic [2:0] i_analog_channel_selector,
   input wire logic [7:0] i_port_two_direction,
   input wire logic [1:0] i_dac_channel_enable,
   input wire logic [1:0] i_dac_pin_direction,
   input wire logic [1:0] i_dac_pin_latch,
   input wire logic i_debug_tool_io_out,
   input wire logic i_debug_tool_io_oe,
   input wire logic i_debug_tool_out,
   output logic [7:0] o_port_data_register,
   output logic [7:0] o_pin_out,
   output logic [7:0] o_pin_oe,
   output logic [7:0] o_alt_in,
   output logic [7:0] o_port_latch,
   output logic [7:0] o_pin_direction_bit,
   output logic o_busy,
   output logic [7:0] o_analog_input_pins_digital,
   output logic [7:0] o_analog_convert_sel,
   output logic [1:0] o_dac_analog_output,
   output logic [1:0] o_dac_pin_oe,
   output logic [1:0] o_debug_pin_out,
   output logic [1:0] o_debug_pin_oe
);
   typedef struct packed {
      logic [7:0] latch;
      logic [7:0] dir;
      logic [7:0] rd;
      pafm_phase_e phase;
   } pafm_state_s;

   pafm_state_s st, next_st;

   // Bit-wise read view: pin level for input bits, latch for output bits
   function automatic logic [7:0] pafm_read(input logic [7:0] lat, input logic [7:0] dir,
                                            input logic [7:0] pin);
      pafm_read = (dir & pin) | (~dir & lat);
   endfunction

   function automatic logic [7:0] pafm_digital_mask(input logic [4:0] cfg);
      logic [7:0] m;
      m = 8'h00;
      if (cfg == PAFM_ANALOG_DIGITAL_PIN_CONFIG_ALL_D0 || cfg == PAFM_ANALOG_DIGITAL_PIN_CONFIG_ALL_D1) begin
         m = 8'hff;
      end else if (cfg < PAFM_ANALOG_DIGITAL_PIN_CONFIG_ALL_D0) begin
         m = 8'((9'h001 << cfg[2:0]) - 9'h001);
      end
      pafm_digital_mask = m;
   endfunction

   logic [7:0] bit_onehot;
   logic [7:0] dig_mask;

   always_comb begin
      next_st = st;
      bit_onehot = 8'(8'h01 << i_bit_sel);
      if (i_dir_wr) begin
         next_st.dir = i_dir_wdata;
      end
      unique case (st.phase)
         PAFM_IDLE: begin
            if (i_bit_op) begin
               // Whole byte is sampled, so input bits carry pin levels forward
               next_st.rd = pafm_read(st.latch, st.dir, i_pin_in); // RULE_16
               next_st.phase = PAFM_WRITE;
               // Kind 0 is undefined; the sampled byte is written back unchanged
               unique case (i_bit_kind)
                  PAFM_BOP_SET: next_st.rd = next_st.rd | bit_onehot;
                  PAFM_BOP_CLR: next_st.rd = next_st.rd & ~bit_onehot;
                  PAFM_BOP_NOT: next_st.rd = next_st.rd ^ bit_onehot;
                  default: next_st.rd = next_st.rd;
               endcase
            end else if (i_wr) begin
               next_st.latch = i_wdata; // RULE_15
            end
         end
         PAFM_WRITE: begin
            next_st.latch = st.rd; // RULE_16 RULE_17
            next_st.phase = PAFM_IDLE;
         end
         default: next_st.phase = PAFM_IDLE;
      endcase
   end

   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         st.latch <= PAFM_LATCH_RST; // RULE_19
         st.dir <= PAFM_DIR_RST;
         st.rd <= 8'h00;
         st.phase <= PAFM_IDLE;
      end else begin
         st <= next_st;
      end
   end

   always_comb begin
      dig_mask = pafm_digital_mask(i_analog_digital_pin_config);
      o_busy = (st.phase == PAFM_WRITE);
      o_port_latch = st.latch;
      o_pin_direction_bit = st.dir;
      // Reads never disturb the latch
      o_port_data_register = pafm_read(st.latch, st.dir, i_pin_in); // RULE_15 RULE_20
      // Alternate output gated by latch; latch must sit at its passive 1 level
      o_pin_out = (i_alt_out_en & i_alt_out & st.latch) | (~i_alt_out_en & st.latch); // RULE_21
      o_pin_oe = ~st.dir;
      o_alt_in = i_pin_in & st.dir; // RULE_22
      o_analog_input_pins_digital = dig_mask & ~i_port_two_direction; // RULE_12
      o_analog_convert_sel = ~dig_mask & i_port_two_direction
                             & 8'(8'h01 << (i_analog_channel_selector & PAFM_ADS_W)); // RULE_13
      o_dac_analog_output = i_dac_channel_enable; // RULE_10
      // Digital drive is released the moment the converter owns the pin
      o_dac_pin_oe = ~i_dac_channel_enable & ~i_dac_pin_direction & i_dac_pin_latch;
      o_debug_pin_out = {i_debug_tool_out, i_debug_tool_io_out}; // RULE_09
      o_debug_pin_oe = {1'b1, i_debug_tool_io_oe}; // RULE_09
   end

   property p_bitop_write;
      @(posedge i_core_clk) disable iff (i_reset)
         (st.phase == PAFM_IDLE && i_bit_op) |=> o_busy ##1 (!o_busy && o_port_latch == $past(st.rd));
   endproperty
   a_bitop_write: assert property (p_bitop_write) else $error("bit op did not write back its byte"); // RULE_16

   property p_busy_single;
      @(posedge i_core_clk) disable iff (i_reset) o_busy |=> !o_busy;
   endproperty
   a_busy_single: assert property (p_busy_single) else $error("write-back phase overran"); // RULE_16

   property p_input_bits_take_pin;
      @(posedge i_core_clk) disable iff (i_reset)
         (st.phase == PAFM_IDLE && i_bit_op && !i_dir_wr) |-> ##2
         ((o_port_latch & $past(st.dir, 2) & ~$past(bit_onehot, 2)) ==
          ($past(i_pin_in, 2) & $past(st.dir, 2) & ~$past(bit_onehot, 2)));
   endproperty
   a_input_bits_take_pin: assert property (p_input_bits_take_pin) else $error("input bits lost pin level"); // RULE_17

   property p_latch_holds;
      @(posedge i_core_clk) disable iff (i_reset)
         (!i_wr && !i_bit_op && st.phase == PAFM_IDLE) |=> $stable(o_port_latch);
   endproperty
   a_latch_holds: assert property (p_latch_holds) else $error("latch changed without a write"); // RULE_19

   property p_reset_clear;
      @(posedge i_core_clk) i_reset |=> (o_port_latch == PAFM_LATCH_RST && !o_busy);
   endproperty
   a_reset_clear: assert property (p_reset_clear) else $error("latch not cleared by reset"); // RULE_19

   property p_read_view;
      @(posedge i_core_clk) disable iff (i_reset)
         (o_port_data_register & ~o_pin_direction_bit) == (o_port_latch & ~o_pin_direction_bit);
   endproperty
   a_read_view: assert property (p_read_view) else $error("output bit read differs from latch"); // RULE_20

   property p_write_latch;
      @(posedge i_core_clk) disable iff (i_reset)
         (i_wr && !i_bit_op && st.phase == PAFM_IDLE) |=> o_port_latch == $past(i_wdata);
   endproperty
   a_write_latch: assert property (p_write_latch) else $error("write did not reach latch"); // RULE_15

   property p_dac_auto;
      @(posedge i_core_clk) disable iff (i_reset)
         o_dac_analog_output == i_dac_channel_enable && (o_dac_pin_oe & i_dac_channel_enable) == 2'h0;
   endproperty
   a_dac_auto: assert property (p_dac_auto) else $error("DAC pin not handed to converter"); // RULE_10

   property p_convert_only_analog;
      @(posedge i_core_clk) disable iff (i_reset)
         (o_analog_convert_sel & o_analog_input_pins_digital) == 8'h00 && $onehot0(o_analog_convert_sel);
   endproperty
   a_convert_only_analog: assert property (p_convert_only_analog) // RULE_13
      else $error("digital pin selected for conversion");

   property p_debug_out;
      @(posedge i_core_clk) disable iff (i_reset)
         o_debug_pin_oe[PAFM_DBG_OUT] && o_debug_pin_out[PAFM_DBG_OUT] == i_debug_tool_out;
   endproperty
   a_debug_out: assert property (p_debug_out) else $error("debug pin not driven"); // RULE_09

   // A low latch must always win, whatever the peripheral drives
   property p_alt_gated;
      @(posedge i_core_clk) disable iff (i_reset)
         (o_pin_out & ~o_port_latch) == 8'h00 && ((o_pin_out ^ o_port_latch) & ~i_alt_out_en) == 8'h00;
   endproperty
   a_alt_gated: assert property (p_alt_gated) else $error("pin drive not gated by latch"); // RULE_21
endmodule
`default_nettype wire

// File: sim/pafm_pin_partner.sv
/*
 Partner model: external peripherals sitting on the eight port pins.
 Assumes the mux pad drive and a level the bench asks the peripherals to show.
*/
`timescale 1ns/1ps
`default_nettype none
module pafm_pin_partner (
   input wire logic [7:0] i_pin_out,
   input wire logic [7:0] i_pin_oe,
   input wire logic [7:0] i_ext_level,
   output logic [7:0] o_pin
);
   // Released bits never echo the mux value, so a stale latch cannot pass a read
   assign o_pin = (i_pin_oe & i_pin_out) | (~i_pin_oe & i_ext_level);
endmodule
`default_nettype wire

// File: sim/test_pafm_port_mux.sv
/*
 Self-checking bench for the port alternate-function mux.
 Assumes the partner model resolves the pads and feeds them back.
*/
`timescale 1ns/1ps
`default_nettype none
module test_pafm_port_mux;
   import pafm_pkg::*;
   logic clk = 1'b0, rst = 1'b1, wr = 1'b0, bop = 1'b0, dwr = 1'b0, dbio = 1'b0, dboe = 1'b0, dbo = 1'b0, busy;
   logic [7:0] wd = 8'h00, dwd = 8'h00, aen = 8'h00, aout = 8'h00, ext = 8'h00, p2dir = 8'hff;
   logic [7:0] pin, rd, pout, poe, ain, lat, dir, adig, aconv;
   logic [1:0] bk = 2'h0, dac_channel_enable = 2'h0, dacdir = 2'h3, daclat = 2'h0, dacout, dacoe, dbgout, dbgoe;
   logic [2:0] bsel = 3'h0, analog_channel_selector = 3'h0;
   logic [4:0] analog_digital_pin_config = PAFM_ANALOG_DIGITAL_PIN_CONFIG_RST;
   int errors = 0, n_compared = 0;
   pafm_port_mux u_pafm_port_mux (.i_core_clk(clk), .i_reset(rst), .i_wr(wr), .i_wdata(wd), .i_bit_op(bop),
      .i_bit_kind(bk), .i_bit_sel(bsel), .i_dir_wr(dwr), .i_dir_wdata(dwd), .i_alt_out_en(aen), .i_alt_out(aout),
      .i_pin_in(pin), .i_analog_digital_pin_config(analog_digital_pin_config), .i_analog_channel_selector(analog_channel_selector),
      .i_port_two_direction(p2dir), .i_dac_channel_enable(dac_channel_enable), .i_dac_pin_direction(dacdir),
      .i_dac_pin_latch(daclat), .i_debug_tool_io_out(dbio), .i_debug_tool_io_oe(dboe), .i_debug_tool_out(dbo),
      .o_port_data_register(rd), .o_pin_out(pout), .o_pin_oe(poe), .o_alt_in(ain), .o_port_latch(lat),
      .o_pin_direction_bit(dir), .o_busy(busy), .o_analog_input_pins_digital(adig),
      .o_analog_convert_sel(aconv), .o_dac_analog_output(dacout), .o_dac_pin_oe(dacoe),
      .o_debug_pin_out(dbgout), .o_debug_pin_oe(dbgoe));
   pafm_pin_partner u_pafm_pin_partner (.i_pin_out(pout), .i_pin_oe(poe), .i_ext_level(ext), .o_pin(pin));
   initial begin
      forever #12.5 clk = ~clk;
   end
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task end_sim;
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task settle;
      @(posedge clk);
      @(negedge clk);
   endtask
   task wbyte(input logic [7:0] v);
      @(posedge clk);
      wr <= 1'b1;
      wd <= v;
      @(posedge clk);
      wr <= 1'b0;
      settle();
   endtask
   task wdir(input logic [7:0] v);
      @(posedge clk);
      dwr <= 1'b1;
      dwd <= v;
      @(posedge clk);
      dwr <= 1'b0;
      settle();
   endtask
   task bitop(input logic [1:0] k, input logic [2:0] s, input logic [7:0] exp);
      int i;
      @(posedge clk);
      bop <= 1'b1;
      bk <= k;
      bsel <= s;
      @(posedge clk);
      bop <= 1'b0;
      @(negedge clk);
      chk("busy", 8'(busy), 8'h01);
      for (i = 0; i < 4 && busy !== 1'b0; i++)
         @(negedge clk);
      if (busy !== 1'b0) begin
         errors++;
         end_sim();
      end
      chk("latch after bit op", lat, exp);
   endtask
   task ana(input logic [4:0] c, input logic [2:0] s, input logic [7:0] p, input logic [7:0] ed,
            input logic [7:0] ec);
      @(posedge clk);
      analog_digital_pin_config <= c;
      analog_channel_selector <= s;
      p2dir <= p;
      settle();
      chk("digital pins", adig, ed);
      chk("convert select", aconv, ec);
   endtask
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      settle();
      chk("latch reset", lat, PAFM_LATCH_RST);
      chk("dir reset", dir, PAFM_DIR_RST);
      chk("oe reset", poe, 8'h00);
      $display("test reset done");
      @(posedge clk);
      ext <= 8'h3c;
      wbyte(8'ha5);
      chk("latch", lat, 8'ha5);
      chk("read input", rd, 8'h3c);
      wdir(8'hf0);
      chk("read mixed", rd, 8'h35);
      chk("latch held", lat, 8'ha5);
      chk("alt in", ain, 8'h30);
      $display("test write read done");
      wdir(8'hfe);
      wbyte(8'h00);
      @(posedge clk);
      ext <= 8'hff;
      bitop(PAFM_BOP_SET, 3'h0, 8'hff);
      bitop(PAFM_BOP_CLR, 3'h7, 8'h7f);
      bitop(PAFM_BOP_NOT, 3'h0, 8'hfe);
      $display("test bit ops done");
      wdir(8'h00);
      wbyte(8'h0f);
      @(posedge clk);
      aen <= 8'hff;
      aout <= 8'h55;
      settle();
      chk("alt pin out", pout, 8'h05);
      chk("pin oe", poe, 8'hff);
      $display("test alt out done");
      @(posedge clk);
      dbio <= 1'b1;
      dboe <= 1'b1;
      dbo <= 1'b1;
      dac_channel_enable <= 2'h1;
      ana(5'h00, 3'h3, 8'hff, 8'h00, 8'h08);
      chk("debug out", 8'(dbgout), 8'h03);
      chk("debug io oe", 8'(dbgoe[PAFM_DBG_IO]), 8'h01);
      chk("dac out", 8'(dacout), 8'h01);
      chk("dac oe", 8'(dacoe), 8'h00);
      @(posedge clk);
      dac_channel_enable <= 2'h2;
      dacdir <= 2'h2;
      daclat <= 2'h1;
      // Analog pins stay in input direction throughout
      ana(5'h03, 3'h1, 8'hfa, 8'h05, 8'h00);
      chk("dac out", 8'(dacout), 8'h02);
      chk("dac oe", 8'(dacoe), 8'h01);
      ana(5'h03, 3'h5, 8'hfa, 8'h05, 8'h20);
      ana(PAFM_ANALOG_DIGITAL_PIN_CONFIG_ALL_D0, 3'h2, 8'h00, 8'hff, 8'h00);
      ana(PAFM_ANALOG_DIGITAL_PIN_CONFIG_ALL_D1, 3'h7, 8'h0f, 8'hf0, 8'h00);
      $display("test analog dac debug done");
      @(posedge clk);
      rst <= 1'b1;
      @(posedge clk);
      rst <= 1'b0;
      settle();
      chk("latch mid reset", lat, PAFM_LATCH_RST);
      chk("dir mid reset", dir, PAFM_DIR_RST);
      $display("test mid reset done");
      end_sim();
   end
endmodule
`default_nettype wire
